// ---- src/sadc_pkg.sv ----
/*
  Constants, states and carrier types for the sampling converter
  control block. Assumes a single 125 MHz core clock.
*/
package sadc_pkg;

  // ------------------------------------------------------------
  // Widths and timing
  // ------------------------------------------------------------
  localparam int SADC_RES_W = 12;
  localparam int SADC_NIB_W = 4;
  localparam int SADC_CNT_W = 10;
  localparam int SADC_CLK_NS = 8;
  // Nominal conversion times, 12-bit and short 8-bit cycle
  localparam int SADC_CONV12_NS = 6400;
  localparam int SADC_CONV8_NS = 4400;
  localparam logic [SADC_CNT_W-1:0] SADC_CONV12_CYC =
    SADC_CNT_W'((SADC_CONV12_NS + SADC_CLK_NS - 1) / SADC_CLK_NS);
  localparam logic [SADC_CNT_W-1:0] SADC_CONV8_CYC =
    SADC_CNT_W'((SADC_CONV8_NS + SADC_CLK_NS - 1) / SADC_CLK_NS);
  localparam logic [SADC_CNT_W-1:0] SADC_CNT_RST = 10'h000;
  localparam logic [SADC_RES_W-1:0] SADC_RESULT_RST = 12'h000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SADC_IDLE  = 3'b001,
    SADC_CONV  = 3'b010,
    SADC_LATCH = 3'b100
  } sadc_state_t;

  // Control pins as they arrive from the host
  typedef struct packed {
    logic chip_en;
    logic chip_sel_n;
    logic read_conv;
    logic word_wide;
    logic byte_select;
  } sadc_ctrl_t;

  // Data pins; hi group is pins 11..4, lo group is pins 3..0
  typedef struct packed {
    logic [SADC_RES_W-1:0] result_bits;
    logic hi_oe_n;
    logic lo_oe_n;
  } sadc_dout_t;

endpackage

// ---- src/sadc_ctrl.sv ----
/*
  Conversion start, length latch, busy and three-state data output
  control of a 12-bit sampling converter.
  Assumes the approximation core presents its word on approx_word
  in the core clock domain; control pins are asynchronous.
*/
module sadc_ctrl
  import sadc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sadc_ctrl_t ctrl_pins,
  input wire logic [SADC_RES_W-1:0] approx_word,
  output sadc_dout_t dout,
  output logic busy,
  output logic hold_cmd
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  sadc_ctrl_t ctrl_m;
  sadc_ctrl_t ctrl_s;
  logic start_q;
  sadc_state_t state;
  sadc_state_t next_state;
  logic [SADC_CNT_W-1:0] cnt;
  logic len8;
  logic [SADC_RES_W-1:0] res;

  // Two stages per pin; ctrl_m feeds only ctrl_s
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_m <= '0;
      ctrl_s <= '0;
    end else begin
      ctrl_m <= ctrl_pins;
      ctrl_s <= ctrl_m;
    end
  end

  // ------------------------------------------------------------
  // Start and read decode
  // ------------------------------------------------------------
  wire chip_on = ctrl_s.chip_en & ~ctrl_s.chip_sel_n;
  wire start_cond = chip_on & ~ctrl_s.read_conv;
  // Level-to-edge on the combined term: whichever input arrives last
  // makes the edge, and all three paths share one delay.
  wire start_evt = start_cond & ~start_q;
  wire go = start_evt & (state == SADC_IDLE);
  wire relatch = start_evt & (state != SADC_IDLE);
  wire rd_ok = chip_on & ctrl_s.read_conv & ~busy;
  wire byte_lo = ~ctrl_s.word_wide & ctrl_s.byte_select;
  wire hi_sel = rd_ok;
  wire lo_sel = rd_ok & ctrl_s.word_wide;
  wire [SADC_CNT_W-1:0] term = len8 ? SADC_CONV8_CYC : SADC_CONV12_CYC;
  wire cnt_done = (cnt >= term - 10'h001);
  // Left-justified low byte: four LSBs then forced zeros
  wire [SADC_RES_W-1:0] lo_byte = {res[SADC_NIB_W-1:0], 8'h00};
  wire [SADC_RES_W-1:0] next_pins = byte_lo ? lo_byte : res;
  // Short cycle leaves the four LSBs at zero
  wire [SADC_RES_W-1:0] latch_word = len8 ? {approx_word[11:4], 4'h0} : approx_word;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_cond;
    end
  end

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  // Next state; starts during a conversion do not restart it
  always_comb begin
    next_state = state;
    case (state)
      SADC_IDLE: begin
        if (go) begin
          next_state = SADC_CONV;
        end
      end
      SADC_CONV: begin
        if (cnt_done) begin
          next_state = SADC_LATCH;
        end
      end
      SADC_LATCH: begin
        next_state = SADC_IDLE;
      end
      default: begin
        next_state = SADC_IDLE;
      end
    endcase
  end

  // State, length latch and cycle counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= SADC_IDLE;
      len8 <= 1'b0;
      cnt <= SADC_CNT_RST;
    end else begin
      state <= next_state;
      // Relatch may shorten or stretch the running cycle
      if (go || relatch) begin
        len8 <= ctrl_s.byte_select;
      end
      cnt <= (state == SADC_CONV) ? cnt + 10'h001 : SADC_CNT_RST;
    end
  end

  // Result latch, busy and the hold kick to the analog core
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      res <= SADC_RESULT_RST;
      busy <= 1'b0;
      hold_cmd <= 1'b0;
    end else begin
      if (state == SADC_CONV && cnt_done) begin
        res <= latch_word;
      end
      busy <= (next_state != SADC_IDLE);
      hold_cmd <= go;
    end
  end

  // ------------------------------------------------------------
  // Three-state data outputs
  // ------------------------------------------------------------
  // Enables held off while a start is pending so no glitch read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dout.result_bits <= SADC_RESULT_RST;
      dout.hi_oe_n <= 1'b1;
      dout.lo_oe_n <= 1'b1;
    end else begin
      dout.result_bits <= next_pins;
      dout.hi_oe_n <= ~(hi_sel & ~start_evt);
      dout.lo_oe_n <= ~(lo_sel & ~start_evt);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [SADC_CNT_W:0] run;
  logic relatch_seen;

  // Busy length and whether a relatch disturbed it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run <= '0;
      relatch_seen <= 1'b0;
    end else begin
      run <= busy ? run + 11'h001 : 11'h000;
      relatch_seen <= go ? 1'b0 : (relatch_seen | relatch);
    end
  end

  sequence s_start;
    start_evt && !busy && state == SADC_IDLE;
  endsequence

  sequence s_busy_rise;
    !busy ##1 busy;
  endsequence

  property p_start_busy;
    @(posedge core_clk) disable iff (!rst_n)
      s_start |=> busy ##1 busy;
  endproperty

  start_busy_a: assert property (p_start_busy) else $error("busy not raised on start");

  idle_noop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!chip_on && !busy) |=> !busy && dout.hi_oe_n && dout.lo_oe_n)
    else $error("activity while deselected");

  busy_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy |-> dout.hi_oe_n && dout.lo_oe_n)
    else $error("outputs driven while busy");

  no_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (busy && start_evt && state == SADC_CONV && !cnt_done) |=> state == SADC_CONV && cnt == $past(cnt) + 10'h001)
    else $error("conversion restarted");

  relatch_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    relatch |=> len8 == $past(ctrl_s.byte_select))
    else $error("byte select not relatched");

  conv_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($fell(busy) && !relatch_seen) |-> run == {1'b0, term} + 11'h001)
    else $error("conversion length wrong");

  word_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd_ok && !start_evt && ctrl_s.word_wide) |=> !dout.hi_oe_n && !dout.lo_oe_n && dout.result_bits == res)
    else $error("word read wrong");

  // Low byte rides on lanes 11..4, left justified
  low_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd_ok && !start_evt && byte_lo) |=> dout.lo_oe_n && dout.result_bits[11:4] == {$past(res[3:0]), 4'h0})
    else $error("low byte format wrong");

  groups_apart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!dout.lo_oe_n) |-> $past(ctrl_s.word_wide) && !dout.hi_oe_n)
    else $error("byte groups overlap");

  short_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($fell(busy) && len8) |-> res[3:0] == 4'h0)
    else $error("short result LSBs not zero");

  latch_first_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(busy) |-> $past(state) == SADC_LATCH && $past(state, 2) == SADC_CONV)
    else $error("busy dropped before latch");

  read_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_busy_rise |-> !$past(rd_ok) || $past(start_evt))
    else $error("read open at conversion start");

  sequence s_read_ready;
    rd_ok && !start_evt;
  endsequence

  // Kick to the core lasts exactly one cycle
  hold_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    hold_cmd |=> !hold_cmd)
    else $error("hold kick too long");

  // Kick coincides with the first busy cycle
  hold_busy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    hold_cmd |-> busy && !$past(busy))
    else $error("hold kick not at busy rise");

  // Busy mirrors the sequencer, never a stale level
  busy_track_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    busy == (state != SADC_IDLE))
    else $error("busy out of step with sequencer");

  // Busy only rises from an accepted start
  rise_go_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(busy) |-> $past(go))
    else $error("busy rose without start");

  // Deselected chip floats every lane
  deselect_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !chip_on |=> dout.hi_oe_n && dout.lo_oe_n)
    else $error("lanes driven while deselected");

  // Convert level never opens the lanes
  convert_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_s.read_conv |=> dout.hi_oe_n && dout.lo_oe_n)
    else $error("lanes driven in convert level");

  // Byte mode keeps the low group shut
  byte_lo_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_s.word_wide |=> dout.lo_oe_n)
    else $error("low group open in byte mode");

  // High byte carries the eight MSBs
  hi_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_read_ready ##0 !ctrl_s.word_wide && !ctrl_s.byte_select) |=> !dout.hi_oe_n && dout.result_bits[11:4] == $past(res[11:4]))
    else $error("high byte wrong");

  // Trailing zeros forced in the low byte
  lo_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    byte_lo |=> dout.result_bits[7:4] == 4'h0)
    else $error("low byte padding not zero");

  // Counter stays below its terminal value in SADC_CONV when no relatch was seen
  cnt_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SADC_CONV && !relatch_seen) |-> cnt < term)
    else $error("conversion counter overran");

  // Counter parked at zero while idle
  idle_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == SADC_IDLE |-> cnt == SADC_CNT_RST)
    else $error("counter not cleared when idle");

  // Latch step lasts one cycle
  latch_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == SADC_LATCH |=> state == SADC_IDLE)
    else $error("latch step stuck");

  // End of count captures the core word
  conv_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == SADC_CONV && cnt_done) |=> state == SADC_LATCH && res == $past(latch_word))
    else $error("result not captured at end");

  // Read conditions open the high group
  read_open_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_read_ready |=> !dout.hi_oe_n)
    else $error("read did not open lanes");

  // Length only moves on a start edge
  len_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state != SADC_IDLE && !relatch) |=> $stable(len8))
    else $error("length changed without start");

  // Sequencer state stays one-hot
  one_hot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $onehot(state))
    else $error("sequencer state corrupt");

endmodule

// ---- testbench/sadc_host_bus.sv ----
/*
  Host data bus model: resolves the three-state result pins.
  Assumes dout comes from sadc_ctrl on the core clock.
*/
module sadc_host_bus
  import sadc_pkg::*;
(
  input wire logic core_clk,
  input wire sadc_dout_t dout,
  output logic [SADC_RES_W-1:0] bus_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus lanes
  // ----------------------------------------
  // Released lanes flip every cycle, so a stale value never passes
  logic [SADC_RES_W-1:0] last = 12'h000;
  assign bus_word[11:4] = !dout.hi_oe_n ? dout.result_bits[11:4] : ~last[11:4];
  assign bus_word[3:0] = !dout.lo_oe_n ? dout.result_bits[3:0] : ~last[3:0];
  // Last lane values
  always @(posedge core_clk) begin
    last <= bus_word;
  end
endmodule

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench for the converter control block.
  Assumes sadc_pkg and the host bus model are compiled first.
*/
module tb_top
  import sadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] trig;
    logic bs_c;
    logic ww;
    logic bs_r;
    logic [11:0] aw;
    logic [11:0] exp;
  } sadc_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  sadc_ctrl_t pins = 5'h0C;
  logic [SADC_RES_W-1:0] aw = 12'h000;
  logic [SADC_RES_W-1:0] bus_word;
  sadc_dout_t dout;
  logic busy;
  logic hold_cmd;
  int n_mismatch = 0;
  int checks = 0;
  int busy_cnt = 0;
  int kicks = 0;
  int ref_k = -1;
  // Trigger input: 0 enable, 1 select, 2 convert, 3 all at once
  sadc_row_t rows [5] = '{
    '{2'h0, 1'b0, 1'b1, 1'b0, 12'hA5C, 12'hA5C},
    '{2'h1, 1'b1, 1'b1, 1'b1, 12'h3E7, 12'h3E0},
    '{2'h2, 1'b0, 1'b0, 1'b0, 12'h9B6, 12'h9B0},
    '{2'h3, 1'b0, 1'b0, 1'b1, 12'h9B6, 12'h600},
    '{2'h2, 1'b1, 1'b0, 1'b1, 12'hC4F, 12'h000}};
  always #4 core_clk = ~core_clk;
  // Busy cycles and core kicks, cleared at each start
  always @(negedge core_clk) begin
    busy_cnt += (busy === 1'b1);
    kicks += (hold_cmd === 1'b1);
  end
  sadc_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .ctrl_pins(pins), .approx_word(aw),
    .dout(dout), .busy(busy), .hold_cmd(hold_cmd));
  sadc_host_bus host (.core_clk(core_clk), .dout(dout), .bus_word(bus_word));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic drv(input logic ce, csn, rc, ww, bs);
    @(negedge core_clk);
    pins <= {ce, csn, rc, ww, bs};
  endtask
  // Bounded wait for busy to reach a level
  task automatic waitb(input logic v, input int lim, output int k);
    for (k = 0; k < lim && busy !== v; k++) @(negedge core_clk);
    if (k == lim) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // Other two inputs settle 64 ns before the trigger moves
  task automatic start(input int t, input logic bs);
    drv(t == 1 || t == 2, t == 1 || t == 3, t == 2 || t == 3, 1'b1, bs);
    idle(7);
    busy_cnt = 0;
    kicks = 0;
    drv(1'b1, 1'b0, 1'b0, 1'b1, bs);
  endtask
  task automatic fin(input logic bs_c);
    int k;
    waitb(1'b0, 1000, k);
    chk(16'(busy_cnt), 16'(bs_c ? SADC_CONV8_CYC : SADC_CONV12_CYC) + 16'h1);
    chk(16'(kicks), 16'h1);
  endtask
  task automatic conv(input logic bs_c);
    int k;
    waitb(1'b1, 10, k);
    ref_k = ref_k < 0 ? k : ref_k;
    chk(16'(k), 16'(ref_k));
    idle(8);
    chk({dout.hi_oe_n, dout.lo_oe_n}, 16'h3);
    fin(bs_c);
  endtask
  // Read pulse held 104 ns before sampling the bus
  task automatic rd(input logic ww, bs, input logic [11:0] exp);
    drv(1'b1, 1'b0, 1'b1, ww, bs);
    idle(13);
    if (ww) begin
      chk(bus_word, exp);
    end else begin
      chk({dout.lo_oe_n, bus_word[11:4]}, {1'b1, exp[11:4]});
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    idle(5);
    chk({busy, hold_cmd, dout.hi_oe_n, dout.lo_oe_n, dout.result_bits}, 16'h3000);
    rst_n <= 1'b1;
    idle(3);
    foreach (rows[i]) begin
      aw <= rows[i].aw;
      start(rows[i].trig, rows[i].bs_c);
      conv(rows[i].bs_c);
      rd(rows[i].ww, rows[i].bs_r, rows[i].exp);
    end
    // Deselected device neither starts nor drives the pins
    for (int j = 0; j < 2; j++) begin
      drv(1'(j), 1'(j), 1'b0, 1'b1, 1'b0);
      idle(8);
      drv(1'(j), 1'(j), 1'b1, 1'b1, 1'b0);
      idle(8);
      chk({busy, dout.hi_oe_n, dout.lo_oe_n}, 16'h3);
    end
    // A second start mid-run only relatches the short length
    aw <= 12'h7D3;
    start(2, 1'b0);
    idle(20);
    drv(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    idle(9);
    chk({busy, dout.hi_oe_n, dout.lo_oe_n}, 16'h7);
    drv(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    fin(1'b1);
    rd(1'b1, 1'b0, 12'h7D0);
    rd(1'b0, 1'b0, 12'h7D0);
    // Byte select toggling never opens both groups
    for (int j = 0; j < 6; j++) begin
      drv(1'b1, 1'b0, 1'b1, 1'b0, 1'(j));
      chk({dout.hi_oe_n, dout.lo_oe_n}, 16'h1);
    end
    drv(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    idle(4);
    chk({dout.hi_oe_n, dout.lo_oe_n}, 16'h3);
    report_and_stop();
  end
endmodule
